//--- core_side_model.sv
`timescale 1ns/1ps
module core_side_model
  import irq_enable_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // source requests
  input  wire logic [NUM_SRC-1:0] src_req,
  output logic      [NUM_SRC-1:0] irq_pending,
  // watchdog
  input  wire wdog_cmd_t          wdog_cmd,
  output logic                    wdog_running,
  output logic      [7:0]         start_cnt,
  output logic      [7:0]         refresh_cnt
);
  assign irq_pending = src_req;
  // once started the watchdog never stops, only a reset halts it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdog_running <= 1'b0;
      start_cnt    <= 8'h00;
      refresh_cnt  <= 8'h00;
    end else begin
      if (wdog_cmd.start) wdog_running <= 1'b1;
      if (wdog_cmd.start) start_cnt <= start_cnt + 8'h01;
      if (wdog_cmd.refresh) refresh_cnt <= refresh_cnt + 8'h01;
    end
  end
endmodule : core_side_model

//--- irq_enable_pkg.sv
package irq_enable_pkg;

  // bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_SRC = 10;
  localparam int NUM_USER_SEL = 4;

  // register addresses
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_A_ADDR = 16'h00A8;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_B_ADDR = 16'h00B8;
  localparam logic [NUM_USER_SEL-1:0][ADDR_W-1:0] USER_SEL_ADDR = {
    16'hFF93, 16'hFF92, 16'hFF91, 16'hFF90
  };
  localparam logic [ADDR_W-1:0] WDOG_STATUS_ADDR = 16'hFF98;
  localparam logic [ADDR_W-1:0] REFRESH_COUNT_ADDR = 16'hFF99;
  localparam logic [ADDR_W-1:0] PENDING_LO_ADDR = 16'hFF9A;
  localparam logic [ADDR_W-1:0] PENDING_HI_ADDR = 16'hFF9B;

  // reset values
  localparam logic [DATA_W-1:0] IRQ_ENABLE_A_RESET = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_ENABLE_B_RESET = 8'h00;
  localparam logic [DATA_W-1:0] USER_SEL_RESET = 8'h00;

  // irq_enable_a fields
  localparam int A_GLOBAL_BIT = 7;
  localparam int A_ARM_BIT = 6;
  localparam int A_SERIAL0_BIT = 4;
  localparam int A_TIMER1_BIT = 3;
  localparam int A_EXT1_BIT = 2;
  localparam int A_TIMER0_BIT = 1;
  localparam int A_EXT0_BIT = 0;

  // reserved bits, stored and read as zero
  localparam int A_RSVD_BIT = 5;
  localparam int B_RSVD_HI_BIT = 7;
  localparam int B_RSVD_LO_BIT = 0;

  // irq_enable_b fields
  localparam int B_START_BIT = 6;
  localparam int B_EXT6_BIT = 5;
  localparam int B_EXT5_BIT = 4;
  localparam int B_EXT4_BIT = 3;
  localparam int B_EXT3_BIT = 2;
  localparam int B_EXT2_BIT = 1;

  // watchdog status fields
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_SEQ_ERR_BIT = 1;
  localparam int ST_RUNNING_BIT = 2;

  // interrupt source indices
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL0 = 4;
  localparam int SRC_EXT2 = 5;
  localparam int SRC_EXT3 = 6;
  localparam int SRC_EXT4 = 7;
  localparam int SRC_EXT5 = 8;
  localparam int SRC_EXT6 = 9;

  // self-clearing flag lifetime, in clock cycles
  localparam int SELF_CLEAR_CYCLES = 12;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic start;
    logic refresh;
  } wdog_cmd_t;

  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_ARMED
  } seq_state_t;

endpackage : irq_enable_pkg

//--- irq_enable_properties.sv
`timescale 1ns/1ps
module irq_enable_properties
  import irq_enable_pkg::*;
#(
  parameter int FLAG_CYCLES = SELF_CLEAR_CYCLES
)(
  // clock and reset
  input wire logic                                clock,
  input wire logic                                rst_n,
  // register port
  input wire reg_req_t                            reg_req,
  input wire logic [DATA_W-1:0]                   reg_rdata,
  // interrupts
  input wire logic [NUM_SRC-1:0]                  irq_pending,
  input wire logic [NUM_SRC-1:0]                  irq_to_core,
  input wire logic                                irq_any,
  // watchdog
  input wire logic                                wdog_running,
  input wire wdog_cmd_t                           wdog_cmd,
  // user select
  input wire logic [NUM_USER_SEL-1:0][DATA_W-1:0] user_irq_select
);
  typedef struct packed {
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] arm_cnt;
  } shadow_t;
  shadow_t            sh_r;
  shadow_t            sh_nxt;
  logic [NUM_SRC-1:0] gate;
  logic               wr_a;
  logic               wr_b;
  logic               wr_b6;
  assign wr_a  = reg_req.wr && reg_req.addr == IRQ_ENABLE_A_ADDR;
  assign wr_b  = reg_req.wr && reg_req.addr == IRQ_ENABLE_B_ADDR;
  assign wr_b6 = wr_b && reg_req.wdata[6];
  assign gate  = {sh_r.en_b[5:1], sh_r.en_a[4:0]} & irq_pending
               & {NUM_SRC{sh_r.en_a[7]}};
  // arm window counter: any write other than an arm ends the window
  always_comb begin
    sh_nxt = sh_r;
    if (sh_r.arm_cnt != 8'h00) sh_nxt.arm_cnt = sh_r.arm_cnt - 8'h01;
    if (reg_req.wr)
      sh_nxt.arm_cnt = (wr_a && reg_req.wdata[6]) ? 8'(FLAG_CYCLES) : 8'h00;
    if (wr_a) sh_nxt.en_a = reg_req.wdata;
    if (wr_b) sh_nxt.en_b = reg_req.wdata;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sh_r <= '0;
    else sh_r <= sh_nxt;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_global_off: assert property (
    !$past(sh_r.en_a[7]) |-> irq_to_core == '0) else $error("global off");
  a_gate_exact: assert property (
    irq_to_core == $past(gate)) else $error("gated request wrong");
  a_any_or: assert property (
    irq_any == |$past(gate)) else $error("any request wrong");
  a_start_idle: assert property (
    wr_b6 && !wdog_running |=> wdog_cmd.start) else $error("no start");
  a_refresh_ok: assert property (
    wr_b6 && sh_r.arm_cnt > 8'h01 && wdog_running |=> wdog_cmd.refresh)
    else $error("no refresh");
  a_refresh_bad: assert property (
    wr_b6 && sh_r.arm_cnt == 8'h00 |=> !wdog_cmd.refresh)
    else $error("refresh unarmed");
  a_refresh_cause: assert property (
    wdog_cmd.refresh |-> $past(wr_b6)) else $error("refresh uncaused");
  a_start_pulse: assert property (
    wdog_cmd.start |=> !wdog_cmd.start) else $error("start too long");
  c_start: cover property (wdog_cmd.start);
  c_refresh: cover property (wdog_cmd.refresh);
  c_any: cover property (irq_any);
endmodule : irq_enable_properties

bind irq_enable_wdog_refresh irq_enable_properties #(
  .FLAG_CYCLES(FLAG_CYCLES)
) props (
  .clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .irq_pending(irq_pending), .irq_to_core(irq_to_core), .irq_any(irq_any),
  .wdog_running(wdog_running), .wdog_cmd(wdog_cmd),
  .user_irq_select(user_irq_select)
);

//--- irq_enable_wdog_refresh.sv
`timescale 1ns/1ps
// Overview of operation
// - global enable low blocks every request to the core.
// - writing 1 to the arm flag begins a watchdog refresh sequence.
// - arm flag clears itself 12 clock cycles after being set.
// - setting the start flag starts a stopped watchdog.
// - refresh only when start directly follows arm; else no refresh.
// - start flag clears itself 12 clock cycles after being set.
// - serial channel 0 request masked while its enable is 0.
// - timer 1 overflow request masked while its enable is 0.
// - timer 0 overflow request masked while its enable is 0.
// - external interrupt 0 masked while its enable is 0.
// - external interrupt 1 masked while its enable is 0.
// - external interrupt 2 masked while its enable is 0.
// - external interrupt 3 masked while its enable is 0.
// - external interrupt 4 masked while its enable is 0.
// - first enable register sits at 0xA8, resets to zero.
module irq_enable_wdog_refresh
  import irq_enable_pkg::*;
#(
  parameter int FLAG_CYCLES = SELF_CLEAR_CYCLES
)(
  // clock and reset
  input  wire logic                                   clock,
  input  wire logic                                   rst_n,
  // register port
  input  wire reg_req_t                               reg_req,
  output logic      [DATA_W-1:0]                      reg_rdata,
  // interrupt sources and core
  input  wire logic [NUM_SRC-1:0]                     irq_pending,
  output logic      [NUM_SRC-1:0]                     irq_to_core,
  output logic                                        irq_any,
  // watchdog
  input  wire logic                                   wdog_running,
  output wdog_cmd_t                                   wdog_cmd,
  // user select fields
  output logic      [NUM_USER_SEL-1:0][DATA_W-1:0]    user_irq_select
);

  typedef struct packed {
    logic [DATA_W-1:0]                   en_a;
    logic [DATA_W-1:0]                   en_b;
    logic [NUM_USER_SEL-1:0][DATA_W-1:0] user_sel;
    logic [DATA_W-1:0]                   rdata;
    seq_state_t                          seq;
    wdog_cmd_t                           cmd;
    logic                                seq_err;
    logic [DATA_W-1:0]                   refresh_cnt;
  } state_t;

  state_t                  s_r;
  state_t                  s_nxt;

  // decoded accesses
  logic                    wr_a;
  logic                    wr_b;
  logic                    wr_status;
  logic [NUM_USER_SEL-1:0] user_wr;
  logic                    arm_set;
  logic                    arm_clr;
  logic                    start_set;
  logic                    start_clr;
  logic                    arm_flag;
  logic                    start_flag;
  logic                    seq_ok;

  // gating inputs
  logic [NUM_SRC-1:0]      src_en;
  logic                    global_en;

  // address decode, one select per register
  logic                    sel_a;
  logic                    sel_b;
  logic                    sel_status;
  logic                    sel_count;
  logic                    sel_pend_lo;
  logic                    sel_pend_hi;
  logic [NUM_USER_SEL-1:0] sel_user;

  // read view of each register
  logic [DATA_W-1:0]       view_a;
  logic [DATA_W-1:0]       view_b;
  logic [DATA_W-1:0]       view_status;
  logic [DATA_W-1:0]       view_pend_lo;
  logic [DATA_W-1:0]       view_pend_hi;
  logic [DATA_W-1:0]       rd_mux;

  always_comb begin
    sel_a       = (reg_req.addr == IRQ_ENABLE_A_ADDR);
    sel_b       = (reg_req.addr == IRQ_ENABLE_B_ADDR);
    sel_status  = (reg_req.addr == WDOG_STATUS_ADDR);
    sel_count   = (reg_req.addr == REFRESH_COUNT_ADDR);
    sel_pend_lo = (reg_req.addr == PENDING_LO_ADDR);
    sel_pend_hi = (reg_req.addr == PENDING_HI_ADDR);
  end

  generate
    for (genvar i = 0; i < NUM_USER_SEL; i++) begin : g_user
      assign sel_user[i] = (reg_req.addr == USER_SEL_ADDR[i]);
      assign user_wr[i]  = reg_req.wr && sel_user[i];
    end
  endgenerate

  assign wr_a      = reg_req.wr && sel_a;
  assign wr_b      = reg_req.wr && sel_b;
  assign wr_status = reg_req.wr && sel_status;

  // an all-bits write of the byte also rewrites the flag bit
  assign arm_set   = wr_a && reg_req.wdata[A_ARM_BIT];
  assign arm_clr   = wr_a && !reg_req.wdata[A_ARM_BIT];
  assign start_set = wr_b && reg_req.wdata[B_START_BIT];
  assign start_clr = wr_b && !reg_req.wdata[B_START_BIT];

  self_clear_flag #(
    .CYCLES (FLAG_CYCLES)
  ) u_arm (
    .clock (clock),
    .rst_n (rst_n),
    .set   (arm_set),
    .clr   (arm_clr),
    .flag  (arm_flag)
  );

  self_clear_flag #(
    .CYCLES (FLAG_CYCLES)
  ) u_start (
    .clock (clock),
    .rst_n (rst_n),
    .set   (start_set),
    .clr   (start_clr),
    .flag  (start_flag)
  );

  // arm write must be the last register write before the start write
  assign seq_ok = (s_r.seq == SEQ_ARMED) && arm_flag;

  // flag bits read live from the self-clearing cells
  always_comb begin
    view_a                      = s_r.en_a;
    view_a[A_ARM_BIT]           = arm_flag;
    view_b                      = s_r.en_b;
    view_b[B_START_BIT]         = start_flag;
    view_status                 = '0;
    view_status[ST_ARMED_BIT]   = seq_ok;
    view_status[ST_SEQ_ERR_BIT] = s_r.seq_err;
    view_status[ST_RUNNING_BIT] = wdog_running;
    view_pend_lo                = irq_pending[DATA_W-1:0];
    view_pend_hi                = '0;
    view_pend_hi[NUM_SRC-DATA_W-1:0] = irq_pending[NUM_SRC-1:DATA_W];
  end

  // selects are exclusive; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (sel_a) begin
      rd_mux = view_a;
    end
    if (sel_b) begin
      rd_mux = view_b;
    end
    if (sel_status) begin
      rd_mux = view_status;
    end
    if (sel_count) begin
      rd_mux = s_r.refresh_cnt;
    end
    if (sel_pend_lo) begin
      rd_mux = view_pend_lo;
    end
    if (sel_pend_hi) begin
      rd_mux = view_pend_hi;
    end
    for (int i = 0; i < NUM_USER_SEL; i++) begin
      if (sel_user[i]) begin
        rd_mux = s_r.user_sel[i];
      end
    end
  end

  always_comb begin
    s_nxt       = s_r;
    s_nxt.cmd   = '0;
    s_nxt.rdata = '0;

    // enable registers, reserved and flag bits stored as zero
    if (wr_a) begin
      s_nxt.en_a = reg_req.wdata;
      s_nxt.en_a[A_ARM_BIT] = 1'b0;
      s_nxt.en_a[A_RSVD_BIT] = 1'b0;
    end
    if (wr_b) begin
      s_nxt.en_b = reg_req.wdata;
      s_nxt.en_b[B_START_BIT] = 1'b0;
      s_nxt.en_b[B_RSVD_HI_BIT] = 1'b0;
      s_nxt.en_b[B_RSVD_LO_BIT] = 1'b0;
    end
    for (int i = 0; i < NUM_USER_SEL; i++) begin
      if (user_wr[i]) begin
        s_nxt.user_sel[i] = reg_req.wdata;
      end
    end

    // refresh sequence tracking
    case (s_r.seq)
      SEQ_IDLE: begin
        if (arm_set) begin
          s_nxt.seq = SEQ_ARMED;
        end
      end
      SEQ_ARMED: begin
        if (start_set) begin
          s_nxt.seq = SEQ_IDLE;
        end else if (arm_set) begin
          s_nxt.seq = SEQ_ARMED;
        end else if (!arm_flag || reg_req.wr) begin
          // any other write or a lapsed arm breaks the order
          s_nxt.seq = SEQ_IDLE;
        end
      end
      default: begin
        s_nxt.seq = SEQ_IDLE;
      end
    endcase

    // error flag: software clears with a 1, a new error wins
    if (wr_status && reg_req.wdata[ST_SEQ_ERR_BIT]) begin
      s_nxt.seq_err = 1'b0;
    end

    if (start_set) begin
      if (!wdog_running) begin
        s_nxt.cmd.start = 1'b1;
      end else if (seq_ok) begin
        s_nxt.cmd.refresh = 1'b1;
        s_nxt.refresh_cnt = s_r.refresh_cnt + 1'b1;
      end else begin
        // out-of-order start while running: no refresh, flag it
        s_nxt.seq_err = 1'b1;
      end
    end

    // read data stand for the single cycle after the strobe
    if (reg_req.rd) begin
      s_nxt.rdata = rd_mux;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r.en_a        <= IRQ_ENABLE_A_RESET;
      s_r.en_b        <= IRQ_ENABLE_B_RESET;
      s_r.user_sel    <= {NUM_USER_SEL{USER_SEL_RESET}};
      s_r.rdata       <= '0;
      s_r.seq         <= SEQ_IDLE;
      s_r.cmd         <= '0;
      s_r.seq_err     <= 1'b0;
      s_r.refresh_cnt <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // per-source enable map
  always_comb begin
    src_en              = '0;
    src_en[SRC_SERIAL0] = s_r.en_a[A_SERIAL0_BIT];
    src_en[SRC_TIMER1]  = s_r.en_a[A_TIMER1_BIT];
    src_en[SRC_TIMER0]  = s_r.en_a[A_TIMER0_BIT];
    src_en[SRC_EXT0]    = s_r.en_a[A_EXT0_BIT];
    src_en[SRC_EXT1]    = s_r.en_a[A_EXT1_BIT];
    src_en[SRC_EXT2]    = s_r.en_b[B_EXT2_BIT];
    src_en[SRC_EXT3]    = s_r.en_b[B_EXT3_BIT];
    src_en[SRC_EXT4]    = s_r.en_b[B_EXT4_BIT];
    src_en[SRC_EXT5]    = s_r.en_b[B_EXT5_BIT];
    src_en[SRC_EXT6]    = s_r.en_b[B_EXT6_BIT];
  end

  assign global_en = s_r.en_a[A_GLOBAL_BIT];

  // registered gate adds one cycle but keeps core inputs glitch free
  irq_gate #(
    .N (NUM_SRC)
  ) u_gate (
    .clock     (clock),
    .rst_n     (rst_n),
    .global_en (global_en),
    .src_en    (src_en),
    .pending   (irq_pending),
    .to_core   (irq_to_core),
    .any       (irq_any)
  );

  assign reg_rdata       = s_r.rdata;
  assign wdog_cmd        = s_r.cmd;
  assign user_irq_select = s_r.user_sel;

endmodule : irq_enable_wdog_refresh

//--- irq_gate.sv
`timescale 1ns/1ps
module irq_gate
  import irq_enable_pkg::*;
#(
  parameter int N = NUM_SRC
)(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // enables
  input  wire logic         global_en,
  input  wire logic [N-1:0] src_en,
  // requests
  input  wire logic [N-1:0] pending,
  output logic      [N-1:0] to_core,
  output logic              any
);

  typedef struct packed {
    logic [N-1:0] req;
    logic         any;
  } gate_state_t;

  gate_state_t  s_r;
  gate_state_t  s_nxt;
  logic [N-1:0] gated;

  generate
    for (genvar i = 0; i < N; i++) begin : g_src
      assign gated[i] = global_en & src_en[i] & pending[i];
    end
  endgenerate

  always_comb begin
    s_nxt     = s_r;
    s_nxt.req = gated;
    s_nxt.any = |gated;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign to_core = s_r.req;
  assign any     = s_r.any;

endmodule : irq_gate

//--- self_clear_flag.sv
`timescale 1ns/1ps
module self_clear_flag
  import irq_enable_pkg::*;
#(
  parameter int CYCLES = SELF_CLEAR_CYCLES
)(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // software side
  input  wire logic set,
  input  wire logic clr,
  // flag
  output logic      flag
);

  typedef struct packed {
    logic             flag;
    logic [CNT_W-1:0] cnt;
  } flag_state_t;

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

  flag_state_t s_r;
  flag_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.flag) begin
      if (s_r.cnt == '0) begin
        s_nxt.flag = 1'b0;
      end else begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
    if (clr) begin
      s_nxt.flag = 1'b0;
    end
    // set wins over both clears and restarts the lifetime
    if (set) begin
      s_nxt.flag = 1'b1;
      s_nxt.cnt  = LOAD;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flag = s_r.flag;

endmodule : self_clear_flag

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top
  import irq_enable_pkg::*;
;
  logic                                clock;
  logic                                rst_n;
  reg_req_t                            reg_req;
  logic [DATA_W-1:0]                   reg_rdata;
  logic [NUM_SRC-1:0]                  src_req;
  logic [NUM_SRC-1:0]                  irq_pending;
  logic [NUM_SRC-1:0]                  irq_to_core;
  logic                                irq_any;
  logic                                wdog_running;
  wdog_cmd_t                           wdog_cmd;
  logic [NUM_USER_SEL-1:0][DATA_W-1:0] user_irq_select;
  logic [7:0]                          start_cnt;
  logic [7:0]                          refresh_cnt;
  int                                  num_errors = 0;
  int                                  total_checks = 0;

  irq_enable_wdog_refresh #(.FLAG_CYCLES(12)) dut (
    .clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .irq_pending(irq_pending), .irq_to_core(irq_to_core), .irq_any(irq_any),
    .wdog_running(wdog_running), .wdog_cmd(wdog_cmd),
    .user_irq_select(user_irq_select));
  core_side_model partner (
    .clock(clock), .rst_n(rst_n), .src_req(src_req),
    .irq_pending(irq_pending), .wdog_cmd(wdog_cmd),
    .wdog_running(wdog_running), .start_cnt(start_cnt),
    .refresh_cnt(refresh_cnt));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task bus(input logic w, input logic r, input logic [15:0] a,
           input logic [7:0] d);
    reg_req <= '{a, d, w, r};
    @(posedge clock);
  endtask : bus
  task idle(input int n);
    reg_req.wr <= 1'b0;
    reg_req.rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle
  // read data is looked at only in the cycle after the read strobe
  // the look happens off the edge, the next request still goes on it
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp,
                      input logic [7:0] m);
    bus(1'b0, 1'b1, a, 8'h00);
    fork
      #1 check(reg_rdata & m, exp);
    join_none
  endtask : rchk

  task t_regs;
    rchk(IRQ_ENABLE_A_ADDR, IRQ_ENABLE_A_RESET, 8'hFF);
    rchk(IRQ_ENABLE_B_ADDR, IRQ_ENABLE_B_RESET, 8'hFF);
    rchk(16'hFF00, 8'h00, 8'hFF);
    for (int i = 0; i < NUM_USER_SEL; i++) begin
      rchk(USER_SEL_ADDR[i], USER_SEL_RESET, 8'hFF);
      bus(1'b1, 1'b0, USER_SEL_ADDR[i], 8'h5A + 8'(i));
      rchk(USER_SEL_ADDR[i], 8'h5A + 8'(i), 8'hFF);
      check(user_irq_select[i], 8'h5A + 8'(i));
    end
  endtask : t_regs

  task t_gate;
    bus(1'b1, 1'b0, IRQ_ENABLE_A_ADDR, 8'h9F);
    bus(1'b1, 1'b0, IRQ_ENABLE_B_ADDR, 8'h3E);
    for (int i = 0; i < NUM_SRC; i++) begin
      src_req <= 10'h001 << i;
      idle(2);
      check(irq_to_core, 10'h001 << i);
      check(irq_any, 1'b1);
      if (i < 5) bus(1'b1, 1'b0, IRQ_ENABLE_A_ADDR, 8'h9F & ~(8'h01 << i));
      else bus(1'b1, 1'b0, IRQ_ENABLE_B_ADDR, 8'h3E & ~(8'h01 << (i - 4)));
      idle(2);
      check(irq_to_core, 10'h000);
      bus(1'b1, 1'b0, (i < 5) ? IRQ_ENABLE_A_ADDR : IRQ_ENABLE_B_ADDR,
          (i < 5) ? 8'h9F : 8'h3E);
    end
    src_req <= 10'h3FF;
    bus(1'b1, 1'b0, IRQ_ENABLE_A_ADDR, 8'h1F);
    idle(2);
    check({irq_any, irq_to_core}, 11'h000);
    bus(1'b1, 1'b0, IRQ_ENABLE_A_ADDR, 8'h9F);
    idle(2);
    check({irq_any, irq_to_core}, 11'h7FF);
    src_req <= 10'h000;
  endtask : t_gate

  task t_wdog;
    bus(1'b1, 1'b0, IRQ_ENABLE_A_ADDR, 8'h40);
    bus(1'b1, 1'b0, IRQ_ENABLE_B_ADDR, 8'h40);
    idle(10);
    rchk(IRQ_ENABLE_A_ADDR, 8'h40, 8'hFF);
    rchk(IRQ_ENABLE_B_ADDR, 8'h40, 8'hFF);
    rchk(IRQ_ENABLE_A_ADDR, 8'h00, 8'hFF);
    rchk(IRQ_ENABLE_B_ADDR, 8'h00, 8'hFF);
    check({wdog_running, start_cnt, refresh_cnt}, 17'h10100);
    bus(1'b1, 1'b0, IRQ_ENABLE_A_ADDR, 8'h40);
    bus(1'b1, 1'b0, IRQ_ENABLE_B_ADDR, 8'h40);
    idle(2);
    check(refresh_cnt, 8'h01);
    bus(1'b1, 1'b0, IRQ_ENABLE_B_ADDR, 8'h40);
    idle(2);
    check(refresh_cnt, 8'h01);
    rchk(WDOG_STATUS_ADDR, 8'h06, 8'h06);
    // a stray write between arm and start must break the pair
    bus(1'b1, 1'b0, IRQ_ENABLE_A_ADDR, 8'h40);
    bus(1'b1, 1'b0, USER_SEL_ADDR[0], 8'h00);
    bus(1'b1, 1'b0, IRQ_ENABLE_B_ADDR, 8'h40);
    idle(2);
    check(refresh_cnt, 8'h01);
    bus(1'b1, 1'b0, IRQ_ENABLE_A_ADDR, 8'h40);
    idle(13);
    bus(1'b1, 1'b0, IRQ_ENABLE_B_ADDR, 8'h40);
    idle(2);
    check({start_cnt, refresh_cnt}, 16'h0101);
    rchk(REFRESH_COUNT_ADDR, 8'h01, 8'hFF);
  endtask : t_wdog

  task results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    src_req = '0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_gate();
    t_wdog();
    idle(2);
    results();
  end
endmodule : tb_top
